// *** spi_pkg.sv ***
// constants, field layouts and carrier types for the serial port block
// assumes an apb master on sys_clk and a pad ring that resolves level/oeN
package spi_pkg;
    // register word indices; byte address is four times the index
    localparam logic [2:0] IDX_CTRL1 = 3'h0;
    localparam logic [2:0] IDX_CTRL2 = 3'h1;
    localparam logic [2:0] IDX_RATE  = 3'h2;
    localparam logic [2:0] IDX_FLAGS = 3'h3;
    localparam logic [2:0] IDX_HOLE  = 3'h4;
    localparam logic [2:0] IDX_DATA  = 3'h5;
    localparam logic [2:0] IDX_PDATA = 3'h6;
    localparam logic [2:0] IDX_PDIR  = 3'h7;
    localparam int unsigned ADDR_LSB_BITS = 2;
    localparam int unsigned ADDR_MIN_W    = 5;

    // reset values
    localparam logic [7:0] RST_CTRL1 = 8'h04;
    localparam logic [7:0] RST_CTRL2 = 8'h08;
    localparam logic [2:0] RST_RATE  = 3'h0;
    localparam logic [3:0] RST_PDIR  = 4'h0;
    localparam logic [3:0] RST_PDAT  = 4'h0;

    // control one fields
    localparam int unsigned C1_IRQ  = 7;
    localparam int unsigned C1_EN   = 6;
    localparam int unsigned C1_OD   = 5;
    localparam int unsigned C1_MST  = 4;
    localparam int unsigned C1_POL  = 3;
    localparam int unsigned C1_PHA  = 2;
    localparam int unsigned C1_SELECT_OUTPUT_ENABLE = 1;
    localparam int unsigned C1_LSB  = 0;
    localparam logic [7:0] C1_EN_MASK = 8'h40;

    // control two fields; only these bits are writable
    localparam int unsigned C2_PUP = 3;
    localparam int unsigned C2_RDS = 2;
    localparam int unsigned C2_SW  = 0;
    localparam logic [7:0] C2_WMASK = 8'h0d;

    // flag positions
    localparam int unsigned FL_DONE = 7;
    localparam int unsigned FL_WCOL = 6;
    localparam int unsigned FL_MODE_FAULT_FLAG = 4;

    // pin slots: slot i is port pin i+4
    localparam int unsigned PIN_MISO = 0;
    localparam int unsigned PIN_MOSI = 1;
    localparam int unsigned PIN_SCK  = 2;
    localparam int unsigned PIN_SS   = 3;
    localparam int unsigned NPINS    = 4;

    // two sck edges per bit, eight bits per byte
    localparam logic [3:0] EDGE_LAST = 4'hf;
    localparam int unsigned DIV_W    = 7;

    typedef enum logic [1:0] {
        SS_FAULT_IN   = 2'b00,
        SS_RESERVED   = 2'b01,
        SS_GPIO       = 2'b10,
        SS_SELECT_OUT = 2'b11
    } ss_mode_t;

    typedef enum logic {
        XF_IDLE = 1'b0,
        XF_RUN  = 1'b1
    } xfer_state_t;

    typedef struct packed {
        logic [3:0] level;
        logic [3:0] oeN;
        logic [3:0] pullupEn;
        logic       reducedDrive;
    } pad_out_t;
endpackage

// *** spi_port.sv ***
// serial port core: apb registers, rate divider, shifter and pin mux
// assumes pins 7..4 arrive asynchronously on pinIn and a pad resolves padOut
module spi_port #(
    parameter int ADDR_W = 5
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [3:0]        pinIn,
    output spi_pkg::pad_out_t      padOut,
    output logic                   irqRequest
);
    // the decoder needs three index bits above the byte lanes
    if (ADDR_W < spi_pkg::ADDR_MIN_W) begin : g_bad_addr
        $error("address width too small for the register map");
    end

    // ---------------- registers ----------------
    logic [7:0]                ctrl1Ff;
    logic [7:0]                ctrl2Ff;
    logic [2:0]                rateFf;
    logic [3:0]                pdirFf;
    logic [3:0]                pdatFf;
    logic [7:0]                rxBufFf;
    logic [31:0]               prdataFf;
    logic                      doneFf;
    logic                      wcolFf;
    logic                      modfFf;
    logic                      doneArmFf;
    logic                      modfArmFf;
    logic [7:0]                shiftFf;
    logic                      outBitFf;
    logic [3:0]                edgeCntFf;
    logic [spi_pkg::DIV_W-1:0] divCntFf;
    logic                      sckFf;
    logic [3:0]                sync1Ff;
    logic [3:0]                sync2Ff;
    logic [3:0]                sync3Ff;
    spi_pkg::xfer_state_t      stateFf;
    spi_pkg::xfer_state_t      nxt_state;

    // ---------------- bus decode ----------------
    wire       setupPh  = psel & ~penable;
    wire       accessPh = psel & penable;
    wire [2:0] wordIdx  = paddr[4:2];
    wire       addrHigh = |(paddr >> spi_pkg::ADDR_MIN_W);
    wire       mapped   = ~addrHigh & (paddr[1:0] == 2'b00) & (wordIdx != spi_pkg::IDX_HOLE);
    wire       wrEn     = accessPh & pwrite & mapped;
    wire       rdEn     = accessPh & ~pwrite & mapped;
    wire       wrCtrl1  = wrEn & (wordIdx == spi_pkg::IDX_CTRL1);
    wire       wrCtrl2  = wrEn & (wordIdx == spi_pkg::IDX_CTRL2);
    wire       wrRate   = wrEn & (wordIdx == spi_pkg::IDX_RATE);
    wire       wrPdat   = wrEn & (wordIdx == spi_pkg::IDX_PDATA);
    wire       wrPdir   = wrEn & (wordIdx == spi_pkg::IDX_PDIR);
    wire       dataWr   = wrEn & (wordIdx == spi_pkg::IDX_DATA);
    wire       dataRd   = rdEn & (wordIdx == spi_pkg::IDX_DATA);
    wire       flagsRd  = rdEn & (wordIdx == spi_pkg::IDX_FLAGS);

    // zero-wait slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = accessPh & ~mapped;
    assign prdata  = prdataFf;

    // ---------------- configuration ----------------
    wire en   = ctrl1Ff[spi_pkg::C1_EN] & ~modfFf;
    wire mst  = ctrl1Ff[spi_pkg::C1_MST];
    wire pha  = ctrl1Ff[spi_pkg::C1_PHA];
    wire pol  = ctrl1Ff[spi_pkg::C1_POL];
    wire lsb  = ctrl1Ff[spi_pkg::C1_LSB];
    wire od   = ctrl1Ff[spi_pkg::C1_OD];
    wire select_output_enable = ctrl1Ff[spi_pkg::C1_SELECT_OUTPUT_ENABLE];
    wire sw   = ctrl2Ff[spi_pkg::C2_SW];
    wire pup  = ctrl2Ff[spi_pkg::C2_PUP];
    wire reduced_drive  = ctrl2Ff[spi_pkg::C2_RDS];
    wire spi_pkg::ss_mode_t ssMode = spi_pkg::ss_mode_t'({pdirFf[spi_pkg::PIN_SS], select_output_enable});

    // ---------------- synchronised pins ----------------
    wire [3:0] pinS  = sync2Ff;
    wire       ssLow = ~pinS[spi_pkg::PIN_SS];
    wire       sckChg = pinS[spi_pkg::PIN_SCK] ^ sync3Ff[spi_pkg::PIN_SCK];

    // receive pin follows role and wire count
    wire rxMaster = sw ? pinS[spi_pkg::PIN_MOSI] : pinS[spi_pkg::PIN_MISO];
    wire rxSlave  = sw ? pinS[spi_pkg::PIN_MISO] : pinS[spi_pkg::PIN_MOSI];
    wire rxBit    = mst ? rxMaster : rxSlave;

    // ---------------- shifter ----------------
    wire       firstBit = lsb ? shiftFf[0] : shiftFf[7];
    wire       loadBit  = lsb ? pwdata[0] : pwdata[7];
    wire [7:0] shifted  = lsb ? {rxBit, shiftFf[7:1]} : {shiftFf[6:0], rxBit};

    // rate divider: half period of 2^field cycles, full period 2^(field+1)
    wire [7:0]                halfCnt  = 8'h01 << rateFf;
    wire [spi_pkg::DIV_W-1:0] halfLast = spi_pkg::DIV_W'(halfCnt - 8'h01);
    wire running = (stateFf == spi_pkg::XF_RUN);
    wire tick    = running & (divCntFf == halfLast);

    // slave edges only count while selected, so a deselect resets framing
    wire slaveSel  = en & ~mst & ssLow;
    wire slvEdge   = slaveSel & sckChg;
    wire anyEdge   = mst ? tick : slvEdge;
    wire sampleEdge = anyEdge & (pha ? edgeCntFf[0] : ~edgeCntFf[0]);
    wire changeEdge = anyEdge & ~sampleEdge;
    wire lastEdge  = anyEdge & (edgeCntFf == spi_pkg::EDGE_LAST);
    wire slaveBusy = ~mst & (edgeCntFf != 4'h0);
    wire busy      = running | slaveBusy;

    wire startMaster = dataWr & en & mst & ~running;
    wire loadSlave   = dataWr & ~mst & ~slaveBusy;
    wire collision   = dataWr & busy;

    // fault only when the select pin is a plain input of an enabled master
    wire faultEv = en & mst & (ssMode == spi_pkg::SS_FAULT_IN) & ssLow;

    // ---------------- flags ----------------
    wire doneClr = doneArmFf & (dataWr | dataRd);
    wire modfClr = modfArmFf & wrCtrl1;
    wire nxt_done = lastEdge | (doneFf & ~doneClr);
    wire nxt_wcol = collision | (wcolFf & ~doneClr);
    wire nxt_mode_fault_flag = faultEv | (modfFf & ~modfClr);
    wire nxt_doneArm = (flagsRd & (doneFf | wcolFf)) | (doneArmFf & ~doneClr);
    wire nxt_modfArm = (flagsRd & modfFf) | (modfArmFf & ~modfClr);

    assign irqRequest = ctrl1Ff[spi_pkg::C1_IRQ] & (doneFf | modfFf);

    // ---------------- read mux ----------------
    wire [7:0] flagsByte = ({7'h00, doneFf} << spi_pkg::FL_DONE)
                         | ({7'h00, wcolFf} << spi_pkg::FL_WCOL)
                         | ({7'h00, modfFf} << spi_pkg::FL_MODE_FAULT_FLAG);
    wire [7:0] ctrl1Rd = ctrl1Ff & ~(modfFf ? spi_pkg::C1_EN_MASK : 8'h00);
    wire [7:0] rdByte =
        (wordIdx == spi_pkg::IDX_CTRL1) ? ctrl1Rd :
        (wordIdx == spi_pkg::IDX_CTRL2) ? ctrl2Ff :
        (wordIdx == spi_pkg::IDX_RATE)  ? {5'h00, rateFf} :
        (wordIdx == spi_pkg::IDX_FLAGS) ? flagsByte :
        (wordIdx == spi_pkg::IDX_DATA)  ? rxBufFf :
        (wordIdx == spi_pkg::IDX_PDATA) ? {pinS, 4'h0} :
        (wordIdx == spi_pkg::IDX_PDIR)  ? {pdirFf, 4'h0} : 8'h00;
    wire [31:0] nxt_prdata = (mapped & ~pwrite) ? {24'h000000, rdByte} : 32'h00000000;

    // ---------------- master sequencer ----------------
    always_comb begin
        nxt_state = stateFf;
        case (stateFf)
            spi_pkg::XF_IDLE: begin
                if (startMaster) begin
                    nxt_state = spi_pkg::XF_RUN;
                end
            end
            spi_pkg::XF_RUN: begin
                // a fault or disable aborts the byte in flight
                if (~en | ~mst | lastEdge) begin
                    nxt_state = spi_pkg::XF_IDLE;
                end
            end
            default: nxt_state = spi_pkg::XF_IDLE;
        endcase
    end

    // ---------------- pin mux ----------------
    // per pin: does the port own it, does it drive, at which level
    wire [3:0] spiOwn;
    wire [3:0] spiDrv;
    wire [3:0] spiLvl;
    assign spiOwn[spi_pkg::PIN_MISO] = en & ~(sw & mst);
    assign spiDrv[spi_pkg::PIN_MISO] = ~mst & ssLow & (~sw | pdirFf[spi_pkg::PIN_MISO]);
    assign spiLvl[spi_pkg::PIN_MISO] = outBitFf;
    assign spiOwn[spi_pkg::PIN_MOSI] = en & ~(sw & ~mst);
    assign spiDrv[spi_pkg::PIN_MOSI] = mst & (~sw | pdirFf[spi_pkg::PIN_MOSI]);
    assign spiLvl[spi_pkg::PIN_MOSI] = outBitFf;
    assign spiOwn[spi_pkg::PIN_SCK]  = en;
    assign spiDrv[spi_pkg::PIN_SCK]  = mst;
    assign spiLvl[spi_pkg::PIN_SCK]  = sckFf;
    assign spiOwn[spi_pkg::PIN_SS]   = en & ~(mst & (ssMode == spi_pkg::SS_GPIO));
    assign spiDrv[spi_pkg::PIN_SS]   = mst & (ssMode == spi_pkg::SS_SELECT_OUT);
    assign spiLvl[spi_pkg::PIN_SS]   = ~running;

    // open drain only pulls low; pullups stay off on any driven pin
    for (genvar i = 0; i < spi_pkg::NPINS; i++) begin : g_pad
        wire drv = spiOwn[i] ? spiDrv[i] : pdirFf[i];
        wire lvl = spiOwn[i] ? spiLvl[i] : pdatFf[i];
        assign padOut.level[i]    = od ? 1'b0 : lvl;
        assign padOut.oeN[i]      = od ? ~(drv & ~lvl) : ~drv;
        assign padOut.pullupEn[i] = pup & ~drv & ~od;
    end
    assign padOut.reducedDrive = reduced_drive;

    // ---------------- sequential logic ----------------
    // pin synchronisers; stage one feeds stage two only
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync1Ff <= 4'hf;
            sync2Ff <= 4'hf;
            sync3Ff <= 4'hf;
        end else begin
            sync1Ff <= pinIn;
            sync2Ff <= sync1Ff;
            sync3Ff <= sync2Ff;
        end
    end

    // software registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl1Ff <= spi_pkg::RST_CTRL1;
            ctrl2Ff <= spi_pkg::RST_CTRL2;
            rateFf  <= spi_pkg::RST_RATE;
            pdirFf  <= spi_pkg::RST_PDIR;
            pdatFf  <= spi_pkg::RST_PDAT;
        end else begin
            if (wrCtrl1) ctrl1Ff <= pwdata[7:0];
            if (wrCtrl2) ctrl2Ff <= pwdata[7:0] & spi_pkg::C2_WMASK;
            if (wrRate)  rateFf  <= pwdata[2:0];
            if (wrPdir)  pdirFf  <= pwdata[7:4];
            if (wrPdat)  pdatFf  <= pwdata[7:4];
        end
    end

    // flags; a set in the clearing cycle wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            doneFf    <= 1'b0;
            wcolFf    <= 1'b0;
            modfFf    <= 1'b0;
            doneArmFf <= 1'b0;
            modfArmFf <= 1'b0;
            prdataFf  <= 32'h00000000;
        end else begin
            doneFf    <= nxt_done;
            wcolFf    <= nxt_wcol;
            modfFf    <= nxt_mode_fault_flag;
            doneArmFf <= nxt_doneArm;
            modfArmFf <= nxt_modfArm;
            if (setupPh) prdataFf <= nxt_prdata;
        end
    end

    // clock generation; the divider only runs during a master byte
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stateFf  <= spi_pkg::XF_IDLE;
            divCntFf <= '0;
            sckFf    <= 1'b0;
        end else begin
            stateFf  <= nxt_state;
            divCntFf <= (~running | tick) ? '0 : spi_pkg::DIV_W'(divCntFf + 1'b1);
            sckFf    <= running ? (sckFf ^ tick) : pol;
        end
    end

    // shifter and edge counter shared by both roles
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shiftFf   <= 8'h00;
            outBitFf  <= 1'b0;
            edgeCntFf <= 4'h0;
            rxBufFf   <= 8'h00;
        end else begin
            if (startMaster | loadSlave) begin
                shiftFf  <= pwdata[7:0];
                outBitFf <= loadBit;
            end else if (sampleEdge) begin
                shiftFf <= shifted;
            end else if (changeEdge) begin
                outBitFf <= firstBit;
            end else if (~mst & ~ssLow) begin
                outBitFf <= firstBit;
            end
            if ((~mst & ~ssLow) | startMaster | ~en) begin
                edgeCntFf <= 4'h0;
            end else if (anyEdge) begin
                edgeCntFf <= edgeCntFf + 4'h1;
            end
            if (lastEdge) begin
                rxBufFf <= pha ? shifted : shiftFf;
            end
        end
    end
endmodule

// *** spi_port_properties.sv ***
// pin, interrupt and timing checks for the serial port
// assumes it is bound to spi_port and sees only that module's ports
module spi_port_properties #(
    parameter int ADDR_W = 5
) (
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [3:0]        pinIn,
    input wire spi_pkg::pad_out_t padOut,
    input wire logic              irqRequest
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic [7:0] ctrlOne_ff;
    logic [7:0] ctrlTwo_ff;
    logic [2:0] rate_ff;
    logic [3:0] dir_ff;
    logic [8:0] gap_ff;
    logic       prevSck_ff;
    logic       prevSs_ff;
    logic       sckSeen_ff;

    // decode of writes and of the select-output configuration
    wire       wrEn   = psel && penable && pwrite;
    wire [2:0] idx    = paddr[4:2];
    wire       sck    = padOut.level[spi_pkg::PIN_SCK];
    wire       ss     = padOut.level[spi_pkg::PIN_SS];
    wire       ssOut  = ctrlOne_ff[6] && ctrlOne_ff[4] && ctrlOne_ff[1] && dir_ff[3];
    wire       sckEvt = sck != prevSck_ff;

    // software view of the registers; a fault never clears these bits
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrlOne_ff <= spi_pkg::RST_CTRL1;
            ctrlTwo_ff <= spi_pkg::RST_CTRL2;
            rate_ff <= spi_pkg::RST_RATE;
            dir_ff <= spi_pkg::RST_PDIR;
        end else if (wrEn) begin
            if (idx == spi_pkg::IDX_CTRL1) ctrlOne_ff <= pwdata[7:0];
            if (idx == spi_pkg::IDX_CTRL2) ctrlTwo_ff <= pwdata[7:0] & spi_pkg::C2_WMASK;
            if (idx == spi_pkg::IDX_RATE) rate_ff <= pwdata[2:0];
            if (idx == spi_pkg::IDX_PDIR) dir_ff <= pwdata[7:4];
        end
    end

    // cycles between clock edges; the first edge is skipped since its lead-in is setup time
    always_ff @(posedge sys_clk) begin
        prevSck_ff <= sck;
        prevSs_ff <= ss;
        gap_ff <= (sys_rst || sckEvt || ss != prevSs_ff) ? 9'h1 : gap_ff + 9'h1;
        sckSeen_ff <= (sys_rst || ss) ? 1'b0 : (sckEvt || sckSeen_ff);
    end

    property p_irq_gate;
        !ctrlOne_ff[7] |-> !irqRequest;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised while masked");

    property p_ss_start;
        ssOut && ss && wrEn && idx == spi_pkg::IDX_DATA |=> !ss [*8];
    endproperty
    a_ss_start: assert property (p_ss_start)
        else $error("select did not fall for the transfer");

    property p_ss_end;
        ssOut && rate_ff <= 3'h4 && $fell(ss) |-> ##[1:300] ss;
    endproperty
    a_ss_end: assert property (p_ss_end)
        else $error("select not released after the byte");

    property p_rate_gap;
        ssOut && !ss && sckEvt && sckSeen_ff |-> gap_ff == (9'h1 << rate_ff);
    endproperty
    a_rate_gap: assert property (p_rate_gap)
        else $error("clock half period off the rate field");

    // the idle level follows a polarity write one cycle late, so skip that cycle
    property p_sck_idle;
        ssOut && !ctrlOne_ff[5] && ss && $stable(ctrlOne_ff[3]) |-> sck == ctrlOne_ff[3];
    endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("idle clock level differs from polarity");

    property p_open_drain;
        ctrlOne_ff[5] |-> padOut.level == 4'h0 && padOut.pullupEn == 4'h0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain pins not open drain");

    property p_pullup;
        (padOut.pullupEn & ~padOut.oeN) == 4'h0 && (ctrlTwo_ff[3] || padOut.pullupEn == 4'h0);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pullup on a driven pin or while off");

    property p_drive;
        padOut.reducedDrive == ctrlTwo_ff[2];
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive strength differs from its bit");

    property p_miso_release;
        (ctrlOne_ff[6] && !ctrlOne_ff[4] && pinIn[3]) [*5] |-> padOut.oeN[spi_pkg::PIN_MISO];
    endproperty
    a_miso_release: assert property (p_miso_release)
        else $error("unselected slave drives its data pin");
endmodule

bind spi_port spi_port_properties #(.ADDR_W(ADDR_W)) spi_port_properties_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinIn(pinIn), .padOut(padOut), .irqRequest(irqRequest));

// *** spi_slave_model.sv ***
// far-side peripheral: a byte slave on its own select line
// assumes lines arrive resolved and change slowly against sys_clk
module spi_slave_model (
    input  wire logic       sys_clk,
    input  wire logic       sckLine,
    input  wire logic       ssLine,
    input  wire logic       mosiLine,
    input  wire logic       phaseOne,
    input  wire logic       lsbFirst,
    input  wire logic [7:0] txByte,
    output logic            misoLine,
    output logic [7:0]      rxByte
);
    logic       prevSck = 1'b0;
    logic       prevSs  = 1'b1;
    logic       bitOut  = 1'b0;
    logic [7:0] shTx    = 8'h00;
    logic [3:0] edges   = 4'h0;
    logic [2:0] k;

    // released line shows the inverse of the last bit, never a stale copy
    assign misoLine = ssLine ? ~bitOut : bitOut;
    assign k = phaseOne ? edges[3:1] : edges[3:1] + 3'h1;

    // one sys_clk of lag on every line, harmless at the rates used
    always @(posedge sys_clk) begin
        prevSck <= sckLine;
        prevSs <= ssLine;
        // an edge that lands with the select rise still counts: it can carry the last sample
        if (ssLine && prevSs) begin
            edges <= 4'h0;
        end else if (prevSs) begin
            shTx <= txByte;
            if (!phaseOne) bitOut <= lsbFirst ? txByte[0] : txByte[7];
        end else if (sckLine != prevSck) begin
            edges <= edges + 4'h1;
            if (edges[0] == phaseOne) begin
                rxByte <= lsbFirst ? {mosiLine, rxByte[7:1]} : {rxByte[6:0], mosiLine};
            end else begin
                bitOut <= lsbFirst ? shTx[k] : shTx[3'h7 - k];
            end
        end
    end
endmodule

// *** spi_phase_pins_and_control_bench.sv ***
// self-checking bench for the serial port as master, slave and single wire
// assumes spi_port, its checker and the slave model are compiled first
module spi_phase_pins_and_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [31:0] val; logic [31:0] mask; logic err;} note_t;

    logic              sys_clk = 1'b0;
    logic              sys_rst, psel, penable, pwrite, extSs, cfgPha, cfgLsb;
    logic [4:0]        paddr;
    logic [31:0]       pwdata, prdata;
    logic              pready, pslverr, irqRequest, misoLine;
    logic [3:0]        pinIn;
    logic [7:0]        sTx, mTx, rxByte, c1;
    spi_pkg::pad_out_t padOut;
    note_t             notes[$];
    note_t             got;
    int                num_errors, n_compared, m, n;
    integer            seed;

    spi_port spi_port_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinIn(pinIn), .padOut(padOut), .irqRequest(irqRequest));
    spi_slave_model spi_slave_model_inst (.sys_clk(sys_clk), .sckLine(pinIn[2]), .ssLine(pinIn[3]),
        .mosiLine(pinIn[1]), .phaseOne(cfgPha), .lsbFirst(cfgLsb), .txByte(sTx),
        .misoLine(misoLine), .rxByte(rxByte));

    // each pin is the port's level when it drives, else the far side; sck held idle low
    assign pinIn = (~padOut.oeN & padOut.level) | (padOut.oeN & {extSs, 1'b0, 1'b1, misoLine});
    always #50 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        if (num_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one apb transfer; the expectation is noted before the request goes out
    task automatic apb(input logic [2:0] idx, input logic isWr, input logic [7:0] d, input logic [7:0] e);
        notes.push_back('{{24'h0, e}, isWr ? 32'h0 : 32'hffffffff, idx == spi_pkg::IDX_HOLE});
        psel <= 1'b1;
        pwrite <= isWr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) num_errors++;
        if (n == 20) final_report();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic regWrite(input logic [2:0] idx, input logic [7:0] d);
        apb(idx, 1'b1, d, 8'h00);
    endtask

    task automatic regRead(input logic [2:0] idx, input logic [7:0] e);
        apb(idx, 1'b0, 8'h00, e);
    endtask

    task automatic waitIrq;
        for (n = 0; n < 3000 && irqRequest !== 1'b1; n++) @(posedge sys_clk);
        if (n == 3000) num_errors++;
        if (n == 3000) final_report();
    endtask

    // completed transfers are matched against the oldest note
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1) begin
            got = notes.pop_front();
            check("prdata", got.val, prdata & got.mask);
            check("pslverr", {31'h0, got.err}, {31'h0, pslverr});
        end
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        final_report();
    end

    initial begin
        seed = 32'h71a177ce;
        {sys_rst, psel, penable, pwrite, extSs, cfgPha, cfgLsb} = 7'b1000100;
        paddr = 5'h00;
        pwdata = 32'h0;
        sTx = 8'h00;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        regRead(spi_pkg::IDX_CTRL1, spi_pkg::RST_CTRL1);
        regRead(spi_pkg::IDX_CTRL2, spi_pkg::RST_CTRL2);
        regRead(spi_pkg::IDX_RATE, 8'h00);
        regWrite(spi_pkg::IDX_FLAGS, 8'hff);
        regRead(spi_pkg::IDX_FLAGS, 8'h00);
        regRead(spi_pkg::IDX_HOLE, 8'h00);
        regWrite(spi_pkg::IDX_PDIR, 8'he0);
        // all four formats, rate 3 or 4 keeps miso clear of the pin synchroniser
        for (m = 0; m < 4; m++) begin
            c1 = {4'b1101, m[1], m[0], 1'b1, m[1] ^ m[0]};
            cfgPha <= m[0];
            cfgLsb <= c1[0];
            sTx <= 8'($random(seed));
            mTx = 8'($random(seed));
            regWrite(spi_pkg::IDX_RATE, {5'h0, 3'h3 + {2'h0, m[0]}});
            regWrite(spi_pkg::IDX_CTRL1, c1);
            regWrite(spi_pkg::IDX_DATA, mTx);
            if (m == 0) regWrite(spi_pkg::IDX_DATA, ~mTx);
            waitIrq();
            regRead(spi_pkg::IDX_FLAGS, m == 0 ? 8'hc0 : 8'h80);
            regRead(spi_pkg::IDX_DATA, sTx);
            check("rxByte", {24'h0, mTx}, {24'h0, rxByte});
            regRead(spi_pkg::IDX_FLAGS, 8'h00);
            check("irqRequest", 32'h0, {31'h0, irqRequest});
        end
        // mode fault from a select input pulled low
        regWrite(spi_pkg::IDX_PDIR, 8'h70);
        regWrite(spi_pkg::IDX_CTRL1, 8'hd0);
        extSs <= 1'b0;
        waitIrq();
        regRead(spi_pkg::IDX_FLAGS, 8'h10);
        regRead(spi_pkg::IDX_CTRL1, 8'h90);
        regWrite(spi_pkg::IDX_CTRL1, 8'h00);
        regRead(spi_pkg::IDX_FLAGS, 8'h00);
        // release the select input so the next master setup does not fault again
        extSs <= 1'b1;
        // single wire master then slave; pins sampled away from the clock edge
        regWrite(spi_pkg::IDX_CTRL2, 8'h01);
        regWrite(spi_pkg::IDX_CTRL1, 8'h50);
        @(negedge sys_clk);
        check("mosiOeN", 32'h0, {31'h0, padOut.oeN[spi_pkg::PIN_MOSI]});
        check("misoOeN", 32'h0, {31'h0, padOut.oeN[spi_pkg::PIN_MISO]});
        @(posedge sys_clk);
        regWrite(spi_pkg::IDX_PDIR, 8'h10);
        regWrite(spi_pkg::IDX_CTRL1, 8'h40);
        extSs <= 1'b0;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        check("sisoOeN", 32'h0, {31'h0, padOut.oeN[spi_pkg::PIN_MISO]});
        @(posedge sys_clk);
        extSs <= 1'b1;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        check("sisoOff", 32'h1, {31'h0, padOut.oeN[spi_pkg::PIN_MISO]});
        @(posedge sys_clk);
        regWrite(spi_pkg::IDX_CTRL2, 8'h04);
        regWrite(spi_pkg::IDX_CTRL1, 8'h20);
        regRead(spi_pkg::IDX_CTRL1, 8'h20);
        final_report();
    end
endmodule
